/* bench/psrb_glob_model.sv */
// Far side of the global access window: one word store.
// Assumes one request at a time, held until its acknowledge.
module psrb_glob_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Window request
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   // Answer delay in cycles
   input wire logic [3:0] lat,
   // Answer
   output logic ack,
   output logic [31:0] rdata
);
   logic [3:0] cnt_r;
   logic [31:0] mem_r;

   // ==========================================================
   // Delayed answer, data toggles outside acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         ack <= 1'b0;
         mem_r <= 32'h0;
         rdata <= 32'h0;
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if (req && !ack && cnt_r == lat) begin
            ack <= 1'b1;
            cnt_r <= 4'h0;
            rdata <= we ? mem_r : mem_r;
            if (we) begin
               mem_r <= wdata;
               rdata <= wdata;
            end
         end else if (req && !ack) begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule

/* bench/psrb_properties.sv */
// Port-level checks on the register bank.
// Assumes BRIDGE_PRESENT holds steady while a request is pending.
module psrb_properties
   import psrb_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic BRIDGE_PRESENT,
   input wire logic CFG_ACK,
   input wire logic CFG_ERR,
   input wire logic [31:0] CFG_RDATA,
   input wire logic GSP_ACK,
   input wire logic SMB_REQ,
   input wire logic SMB_ACK,
   input wire logic EEP_ACK,
   input wire logic GLOB_REQ,
   input wire logic GLOB_WE,
   input wire logic [31:0] GLOB_WDATA,
   input wire logic GLOB_ACK,
   input wire logic [31:0] LANE_STATUS_LO,
   input wire logic [NUM_REGS*32-1:0] REG_IMAGE,
   input wire logic UE_EMU_PULSE,
   input wire logic CE_EMU_PULSE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic [1:0] up_r;
   logic any_ack;
   assign any_ack = CFG_ACK | GSP_ACK | SMB_ACK | EEP_ACK;

   // ==========================================================
   // Cycles since reset, saturating
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end

   // ==========================================================
   // Assertions
   chk_ack_onehot:
      assert property ($onehot0({CFG_ACK, GSP_ACK, SMB_ACK, EEP_ACK}))
      else $error("two paths answered at once");
   chk_ack_single:
      assert property (CFG_ACK |=> !CFG_ACK)
      else $error("config acknowledge longer than one cycle");
   chk_err_mode:
      assert property (CFG_ACK |-> CFG_ERR == !BRIDGE_PRESENT)
      else $error("config refusal does not follow port mode");
   chk_err_zero:
      assert property (CFG_ERR |-> CFG_ACK && CFG_RDATA == 32'h0)
      else $error("refused access returned data");
   chk_emu_pulse:
      assert property ((UE_EMU_PULSE || CE_EMU_PULSE) |-> any_ack
         ##1 !(UE_EMU_PULSE || CE_EMU_PULSE))
      else $error("emulation pulse out of step");
   chk_glob_hold:
      assert property (GLOB_REQ && !GLOB_ACK |=> GLOB_REQ
         && $stable(GLOB_WE) && $stable(GLOB_WDATA))
      else $error("window request changed before acknowledge");
   chk_glob_done:
      assert property ($rose(GLOB_REQ) |-> ##[1:20] GLOB_ACK)
      else $error("window request not answered");
   chk_lane_follow:
      assert property (up_r == 2'h3 |->
         REG_IMAGE[IDX_LANE_STS_LO*32 +: 32] == $past(LANE_STATUS_LO))
      else $error("lane status not following input");
   chk_smb_answer:
      assert property (SMB_REQ && !SMB_ACK |-> ##[1:80] SMB_ACK)
      else $error("serial slave access not answered");
endmodule

/* bench/psrb_tb_top.sv */
// Self-checking bench for the per-port register bank.
// Assumes the checker and window model from this folder.
module psrb_tb_top
   import psrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, brg, cerr, g_req, g_we, g_ack, ue_p, ce_p;
   logic [3:0] req, we, ack, lat;
   logic [11:0] ad [4];
   logic [31:0] wd [4];
   logic [31:0] rd [4];
   logic [31:0] g_addr, g_wd, g_rd, iset, lane0, lane1, link, ue_d, ce_d;
   logic [NUM_REGS*32-1:0] img;
   logic [31:0] mdl [NUM_REGS];
   int n_fail, num_checks, seed, n_emu, n_emu_exp;

   psrb_top dut (.REF_CLK(clk), .RST_N(rst_n), .BRIDGE_PRESENT(brg),
      .CFG_REQ(req[0]), .CFG_WE(we[0]), .CFG_ADDR(ad[0]), .CFG_WDATA(wd[0]),
      .CFG_ACK(ack[0]), .CFG_ERR(cerr), .CFG_RDATA(rd[0]),
      .GSP_REQ(req[1]), .GSP_WE(we[1]), .GSP_ADDR(ad[1]), .GSP_WDATA(wd[1]),
      .GSP_ACK(ack[1]), .GSP_RDATA(rd[1]),
      .SMB_REQ(req[2]), .SMB_WE(we[2]), .SMB_ADDR(ad[2]), .SMB_WDATA(wd[2]),
      .SMB_ACK(ack[2]), .SMB_RDATA(rd[2]),
      .EEP_REQ(req[3]), .EEP_WE(we[3]), .EEP_ADDR(ad[3]), .EEP_WDATA(wd[3]),
      .EEP_ACK(ack[3]), .EEP_RDATA(rd[3]),
      .GLOB_REQ(g_req), .GLOB_WE(g_we), .GLOB_ADDR(g_addr),
      .GLOB_WDATA(g_wd), .GLOB_ACK(g_ack), .GLOB_RDATA(g_rd),
      .INT_STATUS_SET(iset), .IERR_SET_LO(iset), .IERR_SET_HI(iset),
      .LANE_STATUS_LO(lane0), .LANE_STATUS_HI(lane1), .LINK_STATE(link),
      .REG_IMAGE(img), .UE_EMU_PULSE(ue_p), .CE_EMU_PULSE(ce_p),
      .UE_EMU_DATA(ue_d), .CE_EMU_DATA(ce_d));

   psrb_glob_model u_glob (.clk(clk), .rst_n(rst_n), .req(g_req),
      .we(g_we), .addr(g_addr), .wdata(g_wd), .lat(lat), .ack(g_ack),
      .rdata(g_rd));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Emulation strobes seen, counted where settled
   always @(negedge clk) begin
      if (ue_p || ce_p) n_emu++;
   end

   // ==========================================================
   // Helpers
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input int p, input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int i;
      @(negedge clk);
      req[p] = 1'b1;
      we[p] = w;
      ad[p] = a;
      wd[p] = d;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (ack[p] !== 1'b1 && i < 200);
      r = rd[p];
      e = cerr;
      req[p] = 1'b0;
      if (i >= 200) begin
         n_fail++;
         end_of_test();
      end
   endtask

   function automatic logic [31:0] exp_rd(input int i);
      case (REG_KIND[i])
         K_WO: return 32'h0;
         K_RO: return i == IDX_LANE_STS_LO ? lane0 :
            i == IDX_LANE_STS_HI ? lane1 : link;
         default: return mdl[i];
      endcase
   endfunction

   function automatic void mdl_wr(input int i, input logic [31:0] d);
      if (REG_KIND[i] == K_RW) mdl[i] = d;
      if (REG_KIND[i] == K_W1C) mdl[i] = mdl[i] & ~d;
      if (i == IDX_IERR_TST_LO) mdl[IDX_IERR_STS_LO] |= d;
      if (i == IDX_IERR_TST_HI) mdl[IDX_IERR_STS_HI] |= d;
      if (i == IDX_UE_EMU || i == IDX_CE_EMU) n_emu_exp++;
   endfunction

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      int k, i;
      logic [31:0] r, d;
      logic e;
      logic [NUM_REGS*32-1:0] im;
      logic [11:0] undef [4];
      seed = 90;
      undef = '{12'h40c, 12'h8ac, 12'hd98, 12'hff4};
      n_emu = 0;
      n_emu_exp = 0;
      n_fail = 0;
      num_checks = 0;
      rst_n = 1'b0;
      brg = 1'b1;
      req = 4'h0;
      we = 4'h0;
      lat = 4'h0;
      iset = 32'h0;
      for (k = 0; k < 4; k++) begin
         ad[k] = 12'h0;
         wd[k] = 32'h0;
      end
      lane0 = $random(seed);
      lane1 = $random(seed);
      link = $random(seed);
      for (k = 0; k < NUM_REGS; k++) mdl[k] = 32'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (k = 0; k < 49; k++) begin
         acc(k % 4, 1'b0, REG_OFF[k], 32'h0, r, e);
         chk(r, exp_rd(k));
      end
      $display("test reset_values done");
      for (k = 0; k < 40; k++) begin
         i = {$random(seed)} % 49;
         d = $random(seed);
         lane0 = $random(seed);
         lat = d[3:0];
         acc({$random(seed)} % 4, 1'b1, REG_OFF[i], d, r, e);
         mdl_wr(i, d);
         chk(r, 32'h0);
         acc({$random(seed)} % 4, 1'b0, REG_OFF[i], 32'h0, r, e);
         chk(r, exp_rd(i));
      end
      $display("test random_access done");
      for (k = 0; k < 4; k++) begin
         im = img;
         acc(k, 1'b1, undef[k], 32'hffffffff, r, e);
         acc(k, 1'b0, undef[k], 32'h0, r, e);
         chk(r, 32'h0);
         chk({31'h0, img !== im}, 32'h0);
      end
      $display("test undefined done");
      brg = 1'b0;
      acc(0, 1'b1, 12'h400, 32'ha5a5a5a5, r, e);
      chk({31'h0, e}, 32'h1);
      chk(img[31:0], mdl[0]);
      acc(1, 1'b1, 12'h400, 32'h5a5a5a5a, r, e);
      mdl_wr(0, 32'h5a5a5a5a);
      acc(2, 1'b0, 12'h400, 32'h0, r, e);
      chk(r, mdl[0]);
      chk(img[31:0], mdl[0]);
      brg = 1'b1;
      $display("test no_bridge done");
      d = $random(seed);
      acc(3, 1'b1, 12'hff8, 32'h00123450, r, e);
      chk(g_addr, 32'h00123450);
      for (k = 0; k < 4; k++) begin
         lat = 4'(k * 5);
         acc(k, 1'b1, 12'hffc, d + 32'(k), r, e);
         acc((k + 1) % 4, 1'b0, 12'hffc, 32'h0, r, e);
         chk(r, d + 32'(k));
      end
      $display("test global_window done");
      acc(2, 1'b1, 12'hd90, d, r, e);
      mdl_wr(IDX_UE_EMU, d);
      chk(ue_d, d);
      acc(3, 1'b1, 12'hd94, ~d, r, e);
      mdl_wr(IDX_CE_EMU, ~d);
      chk(ce_d, ~d);
      @(negedge clk) iset = 32'h0000ffff;
      @(negedge clk) iset = 32'h0;
      mdl[IDX_INT_STS] |= 32'h0000ffff;
      mdl[IDX_IERR_STS_LO] |= 32'h0000ffff;
      mdl[IDX_IERR_STS_HI] |= 32'h0000ffff;
      acc(0, 1'b1, 12'h404, 32'h000000ff, r, e);
      mdl_wr(IDX_INT_STS, 32'h000000ff);
      acc(3, 1'b0, 12'h404, 32'h0, r, e);
      chk(r, mdl[IDX_INT_STS]);
      acc(1, 1'b0, 12'h484, 32'h0, r, e);
      chk(r, mdl[IDX_IERR_STS_LO]);
      acc(2, 1'b0, 12'h488, 32'h0, r, e);
      chk(r, mdl[IDX_IERR_STS_HI]);
      chk(n_emu, n_emu_exp);
      $display("test side_effects done");
      fork
         acc(0, 1'b1, 12'h890, 32'h11, r, e);
         acc(1, 1'b1, 12'h894, 32'h22, r, e);
         acc(2, 1'b1, 12'h898, 32'h33, r, e);
         acc(3, 1'b1, 12'h8a8, 32'h44, r, e);
      join
      mdl[26] = 32'h11;
      mdl[27] = 32'h22;
      mdl[28] = 32'h33;
      mdl[32] = 32'h44;
      for (k = 26; k < 33; k++) begin
         acc(k % 4, 1'b0, REG_OFF[k], 32'h0, r, e);
         chk(r, exp_rd(k));
      end
      $display("test concurrent done");
      end_of_test();
   end
endmodule

bind psrb_top psrb_properties u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .BRIDGE_PRESENT(BRIDGE_PRESENT), .CFG_ACK(CFG_ACK), .CFG_ERR(CFG_ERR),
   .CFG_RDATA(CFG_RDATA), .GSP_ACK(GSP_ACK), .SMB_REQ(SMB_REQ),
   .SMB_ACK(SMB_ACK), .EEP_ACK(EEP_ACK), .GLOB_REQ(GLOB_REQ),
   .GLOB_WE(GLOB_WE), .GLOB_WDATA(GLOB_WDATA), .GLOB_ACK(GLOB_ACK),
   .LANE_STATUS_LO(LANE_STATUS_LO), .REG_IMAGE(REG_IMAGE),
   .UE_EMU_PULSE(UE_EMU_PULSE), .CE_EMU_PULSE(CE_EMU_PULSE));

/* logic/psrb_pkg.sv */
// Constants for the per-port register bank: offsets, kinds, reset values.
// Assumes 12-bit byte offsets within one function's configuration space.
// Summary of operation
// - Bank occupies offsets 0x400 through 0xFFF
// - Registers act on whole port, any mode
// - No bridge: config path refused, others work
// - Reachable by config, global, SMBus, EEPROM
// - Undefined offset reads return zero
// - Undefined offset writes complete, change nothing
// - Global access address/data at 0xFF8/0xFFC
// - Interrupt status/mask at 0x404/0x408
// - Internal error control, status, severity, test group
// - Seven arbiter counter init registers
// - Four multicast overlay sets after control
// - Uncorrectable/correctable error emulation at 0xD90/0xD94
package psrb_pkg;

   // ==========================================================
   // Geometry
   localparam int NUM_REGS = 50;
   localparam int NUM_PATHS = 4;
   localparam logic [11:0] WIN_LO = 12'h400;
   localparam logic [11:0] WIN_HI = 12'hfff;
   localparam logic [31:0] REG_RESET = 32'h0;

   // ==========================================================
   // Register kinds
   localparam logic [2:0] K_RW = 3'h0;
   localparam logic [2:0] K_W1C = 3'h1;
   localparam logic [2:0] K_WO = 3'h2;
   localparam logic [2:0] K_RO = 3'h3;
   localparam logic [2:0] K_GD = 3'h4;

   // ==========================================================
   // Register map, in index order
   localparam logic [11:0] REG_OFF [0:NUM_REGS-1] = '{
      12'h400, 12'h404, 12'h408, 12'h410, 12'h414, 12'h424, 12'h430,
      12'h480, 12'h484, 12'h488, 12'h48c, 12'h490, 12'h494, 12'h498,
      12'h4a0, 12'h4a4, 12'h510, 12'h51c, 12'h520, 12'h530, 12'h540,
      12'h55c, 12'h690, 12'h710, 12'h880, 12'h88c,
      12'h890, 12'h894, 12'h898, 12'h89c, 12'h8a0, 12'h8a4, 12'h8a8,
      12'h900, 12'h904, 12'h908, 12'h90c, 12'h910, 12'h914, 12'h918,
      12'h91c, 12'h920, 12'h924, 12'h928, 12'h92c, 12'h930,
      12'hd90, 12'hd94, 12'hff8, 12'hffc};

   localparam logic [2:0] REG_KIND [0:NUM_REGS-1] = '{
      K_RW, K_W1C, K_RW, K_RW, K_RW, K_RW, K_RW,
      K_RW, K_W1C, K_W1C, K_RW, K_RW, K_WO, K_WO,
      K_RW, K_RW, K_RW, K_RO, K_RO, K_RW, K_RO,
      K_RW, K_RW, K_RW, K_RW, K_RW,
      K_RW, K_RW, K_RW, K_RW, K_RW, K_RW, K_RW,
      K_RW, K_RW, K_RW, K_RW, K_RW, K_RW, K_RW,
      K_RW, K_RW, K_RW, K_RW, K_RW, K_RW,
      K_WO, K_WO, K_RW, K_GD};

   // ==========================================================
   // Indices of registers with side effects
   localparam int IDX_INT_STS = 1;
   localparam int IDX_IERR_STS_LO = 8;
   localparam int IDX_IERR_STS_HI = 9;
   localparam int IDX_IERR_TST_LO = 12;
   localparam int IDX_IERR_TST_HI = 13;
   localparam int IDX_LANE_STS_LO = 17;
   localparam int IDX_LANE_STS_HI = 18;
   localparam int IDX_LINK_STATE = 20;
   localparam int IDX_UE_EMU = 46;
   localparam int IDX_CE_EMU = 47;
   localparam int IDX_GA_ADDR = 48;

   // ==========================================================
   // Access paths, by arbitration position
   localparam logic [1:0] P_CFG = 2'h0;
   localparam logic [1:0] P_GSP = 2'h1;
   localparam logic [1:0] P_SMB = 2'h2;
   localparam logic [1:0] P_EEP = 2'h3;

   typedef enum {ST_IDLE, ST_EXEC, ST_GLOB} psrb_state_e;

endpackage

/* logic/psrb_top.sv */
// Per-port register bank reached from four access paths.
// Assumes all requesters and the global space run on REF_CLK; each holds
// its request until its acknowledge pulse.
module psrb_top
   import psrb_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Port mode
   input wire logic BRIDGE_PRESENT,
   // Configuration request path
   input wire logic CFG_REQ,
   input wire logic CFG_WE,
   input wire logic [11:0] CFG_ADDR,
   input wire logic [31:0] CFG_WDATA,
   output logic CFG_ACK,
   output logic CFG_ERR,
   output logic [31:0] CFG_RDATA,
   // Global address space path
   input wire logic GSP_REQ,
   input wire logic GSP_WE,
   input wire logic [11:0] GSP_ADDR,
   input wire logic [31:0] GSP_WDATA,
   output logic GSP_ACK,
   output logic [31:0] GSP_RDATA,
   // Management serial slave path
   input wire logic SMB_REQ,
   input wire logic SMB_WE,
   input wire logic [11:0] SMB_ADDR,
   input wire logic [31:0] SMB_WDATA,
   output logic SMB_ACK,
   output logic [31:0] SMB_RDATA,
   // EEPROM loader path
   input wire logic EEP_REQ,
   input wire logic EEP_WE,
   input wire logic [11:0] EEP_ADDR,
   input wire logic [31:0] EEP_WDATA,
   output logic EEP_ACK,
   output logic [31:0] EEP_RDATA,
   // Global access window master
   output logic GLOB_REQ,
   output logic GLOB_WE,
   output logic [31:0] GLOB_ADDR,
   output logic [31:0] GLOB_WDATA,
   input wire logic GLOB_ACK,
   input wire logic [31:0] GLOB_RDATA,
   // Hardware status
   input wire logic [31:0] INT_STATUS_SET,
   input wire logic [31:0] IERR_SET_LO,
   input wire logic [31:0] IERR_SET_HI,
   input wire logic [31:0] LANE_STATUS_LO,
   input wire logic [31:0] LANE_STATUS_HI,
   input wire logic [31:0] LINK_STATE,
   // Port controls
   output logic [NUM_REGS*32-1:0] REG_IMAGE,
   output logic UE_EMU_PULSE,
   output logic CE_EMU_PULSE,
   output logic [31:0] UE_EMU_DATA,
   output logic [31:0] CE_EMU_DATA
);

   // ==========================================================
   // Reset release
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ==========================================================
   // Path gathering
   logic [NUM_PATHS-1:0] req_v;
   logic [NUM_PATHS-1:0] we_v;
   logic [11:0] addr_v [0:NUM_PATHS-1];
   logic [31:0] wdata_v [0:NUM_PATHS-1];
   logic [NUM_PATHS-1:0] ack_r;

   assign req_v = {EEP_REQ, SMB_REQ, GSP_REQ, CFG_REQ};
   assign we_v = {EEP_WE, SMB_WE, GSP_WE, CFG_WE};
   assign addr_v[P_CFG] = CFG_ADDR;
   assign addr_v[P_GSP] = GSP_ADDR;
   assign addr_v[P_SMB] = SMB_ADDR;
   assign addr_v[P_EEP] = EEP_ADDR;
   assign wdata_v[P_CFG] = CFG_WDATA;
   assign wdata_v[P_GSP] = GSP_WDATA;
   assign wdata_v[P_SMB] = SMB_WDATA;
   assign wdata_v[P_EEP] = EEP_WDATA;

   // ==========================================================
   // Round-robin pick, one access at a time
   logic [1:0] rr_ptr_r;
   logic [1:0] pick;
   logic pick_valid;

   always_comb begin
      logic [1:0] j;
      j = 2'h0;
      pick = 2'h0;
      pick_valid = 1'b0;
      for (int k = 0; k < NUM_PATHS; k++) begin
         j = rr_ptr_r + 2'(k);
         if (!pick_valid && req_v[j] && !ack_r[j]) begin
            pick = j;
            pick_valid = 1'b1;
         end
      end
   end

   // ==========================================================
   // Sequencer
   psrb_state_e state_r;
   psrb_state_e state_nxt;
   logic [1:0] cur_r;
   logic cur_we_r;
   logic [11:0] cur_addr_r;
   logic [31:0] cur_wdata_r;
   logic [31:0] rdata_r;
   logic err_r;
   logic [NUM_REGS-1:0] hit;
   logic in_window;
   logic refused;
   logic is_gd;
   logic exec_wr;
   logic [31:0] rd_mux;
   logic [31:0] regs_r [0:NUM_REGS-1];

   // Dword decode; low two address bits ignored
   assign in_window = (cur_addr_r >= WIN_LO) &&
      (cur_addr_r <= WIN_HI);
   // Config path is refused when the bridge function is absent
   assign refused = (cur_r == P_CFG) && !BRIDGE_PRESENT;

   generate
      for (genvar d = 0; d < NUM_REGS; d++) begin : g_dec
         assign hit[d] = in_window && !refused &&
            (cur_addr_r[11:2] == REG_OFF[d][11:2]);
      end
   endgenerate

   assign is_gd = |(hit & (NUM_REGS'(1) << (NUM_REGS - 1)));
   assign exec_wr = (state_r == ST_EXEC) && cur_we_r && !is_gd;

   always_comb begin
      rd_mux = 32'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i] && REG_KIND[i] != K_WO && REG_KIND[i] != K_GD) begin
            rd_mux = regs_r[i];
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (pick_valid) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (is_gd) begin
               state_nxt = ST_GLOB;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_GLOB: begin
            if (GLOB_ACK) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Latch the winning request whole, so a dword never tears
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cur_r <= 2'h0;
         cur_we_r <= 1'b0;
         cur_addr_r <= 12'h0;
         cur_wdata_r <= 32'h0;
         rr_ptr_r <= 2'h0;
      end else if (state_r == ST_IDLE && pick_valid) begin
         cur_r <= pick;
         cur_we_r <= we_v[pick];
         cur_addr_r <= addr_v[pick];
         cur_wdata_r <= wdata_v[pick];
         rr_ptr_r <= pick + 2'h1;
      end
   end

   // Acknowledge and read data
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ack_r <= '0;
         rdata_r <= 32'h0;
         err_r <= 1'b0;
      end else begin
         ack_r <= '0;
         err_r <= 1'b0;
         if (state_r == ST_EXEC && !is_gd) begin
            ack_r[cur_r] <= 1'b1;
            rdata_r <= cur_we_r ? 32'h0 : rd_mux;
            err_r <= refused;
         end else if (state_r == ST_GLOB && GLOB_ACK) begin
            ack_r[cur_r] <= 1'b1;
            rdata_r <= cur_we_r ? 32'h0 : GLOB_RDATA;
            err_r <= 1'b0;
         end
      end
   end

   assign CFG_ACK = ack_r[P_CFG];
   assign GSP_ACK = ack_r[P_GSP];
   assign SMB_ACK = ack_r[P_SMB];
   assign EEP_ACK = ack_r[P_EEP];
   assign CFG_ERR = err_r;
   assign CFG_RDATA = rdata_r;
   assign GSP_RDATA = rdata_r;
   assign SMB_RDATA = rdata_r;
   assign EEP_RDATA = rdata_r;

   // ==========================================================
   // Global access window master
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         GLOB_REQ <= 1'b0;
         GLOB_WE <= 1'b0;
         GLOB_WDATA <= 32'h0;
      end else if (state_r == ST_EXEC && is_gd) begin
         GLOB_REQ <= 1'b1;
         GLOB_WE <= cur_we_r;
         GLOB_WDATA <= cur_wdata_r;
      end else if (GLOB_ACK) begin
         GLOB_REQ <= 1'b0;
      end
   end

   assign GLOB_ADDR = regs_r[IDX_GA_ADDR];

   // ==========================================================
   // Register storage
   logic [31:0] wmask [0:NUM_REGS-1];

   generate
      for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
         logic [31:0] set_vec;
         logic [31:0] ro_vec;

         assign wmask[g] = (exec_wr && hit[g]) ? cur_wdata_r : 32'h0;

         // Hardware events; error test writes inject status bits
         if (g == IDX_INT_STS) begin : g_set_int
            assign set_vec = INT_STATUS_SET;
         end else if (g == IDX_IERR_STS_LO) begin : g_set_lo
            assign set_vec = IERR_SET_LO | wmask[IDX_IERR_TST_LO];
         end else if (g == IDX_IERR_STS_HI) begin : g_set_hi
            assign set_vec = IERR_SET_HI | wmask[IDX_IERR_TST_HI];
         end else begin : g_set_none
            assign set_vec = 32'h0;
         end

         if (g == IDX_LANE_STS_LO) begin : g_ro_lo
            assign ro_vec = LANE_STATUS_LO;
         end else if (g == IDX_LANE_STS_HI) begin : g_ro_hi
            assign ro_vec = LANE_STATUS_HI;
         end else if (g == IDX_LINK_STATE) begin : g_ro_link
            assign ro_vec = LINK_STATE;
         end else begin : g_ro_none
            assign ro_vec = 32'h0;
         end

         always_ff @(posedge REF_CLK or negedge rst_n_r) begin
            if (!rst_n_r) begin
               regs_r[g] <= REG_RESET;
            end else if (REG_KIND[g] == K_W1C) begin
               // Set wins over a simultaneous clear
               regs_r[g] <= (regs_r[g] & ~wmask[g]) | set_vec;
            end else if (REG_KIND[g] == K_RO) begin
               regs_r[g] <= ro_vec;
            end else if (exec_wr && hit[g] && REG_KIND[g] != K_GD) begin
               regs_r[g] <= cur_wdata_r;
            end
         end

         assign REG_IMAGE[g*32 +: 32] = regs_r[g];
      end
   endgenerate

   // ==========================================================
   // Error emulation strobes
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         UE_EMU_PULSE <= 1'b0;
         CE_EMU_PULSE <= 1'b0;
      end else begin
         UE_EMU_PULSE <= exec_wr && hit[IDX_UE_EMU];
         CE_EMU_PULSE <= exec_wr && hit[IDX_CE_EMU];
      end
   end

   assign UE_EMU_DATA = regs_r[IDX_UE_EMU];
   assign CE_EMU_DATA = regs_r[IDX_CE_EMU];

endmodule
